// ### pwm_stage_pkg.sv

`default_nettype none

package pwm_stage_pkg;

   // ==================================================================
   // register indices (byte address is four times the index)
   // ==================================================================
   localparam logic [7:0] IDX_DB_CTRL = 8'h0F; // deadband_control
   localparam logic [7:0] IDX_RISE    = 8'h10; // rise_delay_count
   localparam logic [7:0] IDX_FALL    = 8'h11; // fall_delay_count
   localparam logic [7:0] IDX_CHOP    = 8'h1E; // chopper_control
   localparam logic [7:0] IDX_STAT    = 8'h1F; // stage status

   // ==================================================================
   // field positions
   // ==================================================================
   localparam int DB_OUT_LSB   = 0;  // out mode, bit1 = S1, bit0 = S0
   localparam int DB_POL_LSB   = 2;  // polarity, bit2 = S2, bit3 = S3
   localparam int DB_IN_LSB    = 4;  // input source select
   localparam int DB_TBDIV_LSB = 6;  // tick prescaler, 2^n
   localparam int CH_EN_BIT    = 0;  // chopper_enable_bit
   localparam int CH_OSW_LSB   = 1;  // first_pulse_width_field
   localparam int CH_FREQ_LSB  = 5;  // carrier_frequency_field
   localparam int CH_DUTY_LSB  = 8;  // carrier_duty_field

   // ==================================================================
   // widths, reset values and write masks
   // ==================================================================
   localparam int DLY_W = 10;                    // delay counter width
   localparam logic [15:0] DB_CTRL_RST = 16'h0000;
   localparam logic [DLY_W-1:0] DLY_RST = 10'h000;
   localparam logic [15:0] CHOP_RST    = 16'h0000;
   localparam logic [15:0] DB_CTRL_MSK = 16'h00FF;
   localparam logic [15:0] CHOP_MSK    = 16'h07FF;

   // ==================================================================
   // clock period in ns and timing counts
   // ==================================================================
   localparam int CLK_PERIOD_NS = 4;             // 250 MHz system clock
   localparam logic [7:0] FP_UNIT_CLKS = 8'h08;  // first pulse step
   localparam logic [2:0] DUTY_MAX = 3'h6;       // 7/8 high at most

   // ==================================================================
   // bus constants
   // ==================================================================
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic       HRESP_OKAY    = 1'b0;

   // input source choices for the two delay lines
   typedef enum logic [1:0] {
      SRC_A_BOTH,
      SRC_A_FALL_B_RISE,
      SRC_A_RISE_B_FALL,
      SRC_B_BOTH
   } in_src_t;

endpackage : pwm_stage_pkg

`default_nettype wire

// ### edge_delay.sv
`timescale 1ns/1ps
`default_nettype none

// ====================================================================
// edge delay line: holds back one edge direction by a tick count
// ====================================================================
module edge_delay #(
   parameter logic RISE_EDGE = 1'b1              // 1 rise, 0 fall
) (
   // clock and reset
   input  wire logic                           clk,
   input  wire logic                           rst,
   // time-base enable and delay setting
   input  wire logic                           tick,
   input  wire logic [pwm_stage_pkg::DLY_W-1:0] count,
   // signal path
   input  wire logic                           sig_in,
   output logic                                sig_out
);
   import pwm_stage_pkg::*;

   logic [DLY_W-1:0] cnt_q;                      // ticks spent pending
   logic             out_q;                      // delayed level

   // edge waiting is the delayed direction
   wire lead_edge = RISE_EDGE ? sig_in : ~sig_in;
   // enough ticks elapsed for the pending edge
   wire held_long = (cnt_q >= count);

   // a glitch shorter than the delay is swallowed: the
   // counter restarts whenever input returns to the output level
   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_q <= DLY_RST;
         out_q <= 1'b0;
      end else if (sig_in == out_q) begin
         cnt_q <= DLY_RST;
      end else if (!lead_edge || held_long) begin
         out_q <= sig_in;
         cnt_q <= DLY_RST;
      end else if (tick) begin
         cnt_q <= cnt_q + 10'h001;
      end
   end

   assign sig_out = out_q;

endmodule : edge_delay

`default_nettype wire

// ### pwm_deadband_chopper_stage.sv
`timescale 1ns/1ps
`default_nettype none

// ====================================================================
// dead-band and chopper output stage for a pwm channel pair
// ====================================================================
module pwm_deadband_chopper_stage (
   // clock and reset
   input  wire logic        CLK,
   input  wire logic        RST,
   // ahb-lite slave
   input  wire logic        HSEL,
   input  wire logic [31:0] HADDR,
   input  wire logic [1:0]  HTRANS,
   input  wire logic        HWRITE,
   input  wire logic [2:0]  HSIZE,
   input  wire logic [31:0] HWDATA,
   input  wire logic        HREADY,
   output logic      [31:0] HRDATA,
   output logic             HREADYOUT,
   output logic             HRESP,
   // channels from the action qualifier
   input  wire logic        PWM_A_IN,
   input  wire logic        PWM_B_IN,
   // conditioned outputs toward the gate drivers
   output logic             PWM_A_OUT,
   output logic             PWM_B_OUT
);
   import pwm_stage_pkg::*;

   // =================================================================
   // functions
   // =================================================================

   // word index of a byte address
   function automatic logic [7:0] reg_index(input logic [31:0] a);
      reg_index = a[9:2];
   endfunction : reg_index

   // last count of the tick prescaler for divide by 2^n
   function automatic logic [2:0] div_last(input logic [1:0] n);
      unique case (n)
         2'h0: div_last = 3'h0;
         2'h1: div_last = 3'h1;
         2'h2: div_last = 3'h3;
         2'h3: div_last = 3'h7;
      endcase
   endfunction : div_last

   // =================================================================
   // registers
   // =================================================================
   logic [15:0]      db_ctrl_q;                  // deadband_control
   logic [DLY_W-1:0] rise_cnt_q;                 // rise_delay_count
   logic [DLY_W-1:0] fall_cnt_q;                 // fall_delay_count
   logic [15:0]      chop_ctrl_q;                // chopper_control

   // =================================================================
   // ahb-lite slave
   // =================================================================
   logic        wr_pend_q;                       // write data phase due
   logic [7:0]  wr_idx_q;                        // its word index
   logic [31:0] rdata_q;                         // read data register
   logic        ready_q;                         // hreadyout source
   logic        resp_q;                          // hresp source
   logic [15:0] status_w;                        // live status word

   // address phase taken when selected and the bus is ready;
   // only whole-word single transfers are expected
   wire        addr_ok  = HSEL && HREADY && HTRANS == HTRANS_NONSEQ;
   wire        rd_start = addr_ok && !HWRITE;
   wire        wr_start = addr_ok && HWRITE;
   wire [7:0]  rd_idx   = reg_index(HADDR);

   // read decode; unmapped words answer zero
   wire [31:0] rd_mux =
      (rd_idx == IDX_DB_CTRL) ? {16'h0000, db_ctrl_q}    :
      (rd_idx == IDX_RISE)    ? {22'h000000, rise_cnt_q} :
      (rd_idx == IDX_FALL)    ? {22'h000000, fall_cnt_q} :
      (rd_idx == IDX_CHOP)    ? {16'h0000, chop_ctrl_q}  :
      (rd_idx == IDX_STAT)    ? {16'h0000, status_w}     :
                                32'h00000000;

   // write strobes, one per register, in the data phase
   wire wr_db   = wr_pend_q && wr_idx_q == IDX_DB_CTRL;
   wire wr_rise = wr_pend_q && wr_idx_q == IDX_RISE;
   wire wr_fall = wr_pend_q && wr_idx_q == IDX_FALL;
   wire wr_chop = wr_pend_q && wr_idx_q == IDX_CHOP;

   // bus phase tracking; the slave never inserts wait states
   always_ff @(posedge CLK) begin
      if (RST) begin
         wr_pend_q <= 1'b0;
         wr_idx_q  <= 8'h00;
         ready_q   <= 1'b1;
         resp_q    <= HRESP_OKAY;
      end else begin
         wr_pend_q <= wr_start;
         wr_idx_q  <= wr_start ? reg_index(HADDR) : wr_idx_q;
      end
   end

   // read data is captured at the address edge and stands through
   // the data phase, until the next read replaces it
   always_ff @(posedge CLK) begin
      if (RST) begin
         rdata_q <= 32'h00000000;
      end else if (rd_start) begin
         rdata_q <= rd_mux;
      end
   end

   // configuration writes; narrow registers drop the upper bits
   always_ff @(posedge CLK) begin
      if (RST) begin
         db_ctrl_q   <= DB_CTRL_RST;
         rise_cnt_q  <= DLY_RST;
         chop_ctrl_q <= CHOP_RST;
      end else begin
         if (wr_db) begin
            db_ctrl_q <= HWDATA[15:0] & DB_CTRL_MSK;
         end
         if (wr_rise) begin
            rise_cnt_q <= HWDATA[DLY_W-1:0];
         end
         if (wr_chop) begin
            chop_ctrl_q <= HWDATA[15:0] & CHOP_MSK;
         end
      end
   end

   // the fall count has its own register and strobe
   always_ff @(posedge CLK) begin
      if (RST) begin
         fall_cnt_q <= DLY_RST;
      end else if (wr_fall) begin
         fall_cnt_q <= HWDATA[DLY_W-1:0];
      end
   end

   assign HRDATA    = rdata_q;
   assign HREADYOUT = ready_q;
   assign HRESP     = resp_q;

   // =================================================================
   // control field decode
   // =================================================================
   wire       mode_s0  = db_ctrl_q[DB_OUT_LSB];      // fall delay on B
   wire       mode_s1  = db_ctrl_q[DB_OUT_LSB+1];    // rise delay on A
   wire       pol_s2   = db_ctrl_q[DB_POL_LSB];      // invert A path
   wire       pol_s3   = db_ctrl_q[DB_POL_LSB+1];    // invert B path
   wire [1:0] tb_div   = db_ctrl_q[DB_TBDIV_LSB +: 2];
   in_src_t   in_src;
   assign in_src = in_src_t'(db_ctrl_q[DB_IN_LSB +: 2]);

   wire       chop_en  = chop_ctrl_q[CH_EN_BIT];
   wire [3:0] fp_code  = chop_ctrl_q[CH_OSW_LSB +: 4];
   wire [2:0] frq_code = chop_ctrl_q[CH_FREQ_LSB +: 3];
   wire [2:0] dut_raw  = chop_ctrl_q[CH_DUTY_LSB +: 3];
   // code 7 has no ratio of its own and is held at 87.5%
   wire [2:0] dut_code = (dut_raw > DUTY_MAX) ? DUTY_MAX : dut_raw;

   // =================================================================
   // time-base tick divider
   // =================================================================
   logic [2:0] tb_cnt_q;                         // prescaler count
   logic       tick_q;                           // one-cycle enable

   // tick is a prescaled system clock, one pulse per period
   always_ff @(posedge CLK) begin
      if (RST) begin
         tb_cnt_q <= 3'h0;
         tick_q   <= 1'b0;
      end else if (tb_cnt_q >= div_last(tb_div)) begin
         tb_cnt_q <= 3'h0;
         tick_q   <= 1'b1;
      end else begin
         tb_cnt_q <= tb_cnt_q + 3'h1;
         tick_q   <= 1'b0;
      end
   end

   // =================================================================
   // dead-band generator
   // =================================================================
   logic a_in_q;                                 // aligned with delays
   logic b_in_q;
   logic red_w;                                  // rise-delayed signal
   logic fed_w;                                  // fall-delayed signal

   // the two action-qualifier channels feed the stage directly
   wire rise_src = in_src == SRC_A_FALL_B_RISE || in_src == SRC_B_BOTH
                   ? PWM_B_IN : PWM_A_IN;
   wire fall_src = in_src == SRC_A_RISE_B_FALL || in_src == SRC_B_BOTH
                   ? PWM_B_IN : PWM_A_IN;

   // one stage of delay so undelayed and delayed paths line up
   always_ff @(posedge CLK) begin
      if (RST) begin
         a_in_q <= 1'b0;
         b_in_q <= 1'b0;
      end else begin
         a_in_q <= PWM_A_IN;
         b_in_q <= PWM_B_IN;
      end
   end

   edge_delay #(.RISE_EDGE(1'b1)) u_rise (
      .clk     (CLK),
      .rst     (RST),
      .tick    (tick_q),
      .count   (rise_cnt_q),
      .sig_in  (rise_src),
      .sig_out (red_w)
   );

   edge_delay #(.RISE_EDGE(1'b0)) u_fall (
      .clk     (CLK),
      .rst     (RST),
      .tick    (tick_q),
      .count   (fall_cnt_q),
      .sig_in  (fall_src),
      .sig_out (fed_w)
   );

   // output mode picks delayed or plain per channel; polarity only
   // acts on a delayed path, so a bypassed channel ignores it.
   // with S1=S0=1: S3,S2 = 10 gives the true pair, 01 the inverted
   // pair, 00 both active high, 11 both active low
   wire db_a = mode_s1 ? (red_w ^ pol_s2) : a_in_q;
   wire db_b = mode_s0 ? (fed_w ^ pol_s3) : b_in_q;
   // mode 00 passes both, 01 and 10 keep one channel plain

   // =================================================================
   // chopper carrier
   // =================================================================
   logic [2:0] pre_cnt_q;                        // carrier prescaler
   logic [2:0] phase_q;                          // eighth of a period

   // carrier period is eight steps of (frequency code + 1) clocks
   always_ff @(posedge CLK) begin
      if (RST) begin
         pre_cnt_q <= 3'h0;
         phase_q   <= 3'h0;
      end else if (pre_cnt_q >= frq_code) begin
         pre_cnt_q <= 3'h0;
         phase_q   <= phase_q + 3'h1;
      end else begin
         pre_cnt_q <= pre_cnt_q + 3'h1;
      end
   end

   // high for (duty code + 1) of eight steps
   wire carrier = (phase_q <= dut_code);

   // =================================================================
   // one-shot and chopping, one lane per channel
   // =================================================================
   wire [1:0] db_out = {db_b, db_a};
   logic [1:0] chop_out;                         // lane results
   logic [1:0] os_act;                           // one-shot running

   // first pulse length in clocks, 8 times (code + 1)
   wire [7:0] fp_clks = FP_UNIT_CLKS * ({4'h0, fp_code} + 8'h01);

   genvar ch;
   generate
      for (ch = 0; ch < 2; ch++) begin : g_lane
         logic       prev_q;                     // last pwm level
         logic [7:0] os_cnt_q;                   // clocks of pulse left

         wire rise_edge = db_out[ch] && !prev_q;

         // retriggers on every rising pwm edge; a falling edge
         // ends the pulse early since the and gate blocks it anyway
         always_ff @(posedge CLK) begin
            if (RST) begin
               prev_q   <= 1'b0;
               os_cnt_q <= 8'h00;
            end else begin
               prev_q <= db_out[ch];
               if (rise_edge) begin
                  os_cnt_q <= fp_clks;
               end else if (!db_out[ch]) begin
                  os_cnt_q <= 8'h00;
               end else if (os_cnt_q != 8'h00) begin
                  os_cnt_q <= os_cnt_q - 8'h01;
               end
            end
         end

         // the rising edge cycle already counts as the first clock
         assign os_act[ch] = rise_edge || os_cnt_q > 8'h01;
         assign chop_out[ch] = chop_en
            ? db_out[ch] && (os_act[ch] || carrier)
            : db_out[ch];
      end
   endgenerate

   // =================================================================
   // output flops and status
   // =================================================================
   logic out_a_q;
   logic out_b_q;

   // pins are driven only from flops so no decode glitch escapes
   always_ff @(posedge CLK) begin
      if (RST) begin
         out_a_q <= 1'b0;
         out_b_q <= 1'b0;
      end else begin
         out_a_q <= chop_out[0];
         out_b_q <= chop_out[1];
      end
   end

   assign PWM_A_OUT = out_a_q;
   assign PWM_B_OUT = out_b_q;

   // live view: pins, dead-band levels, one-shots, carrier
   assign status_w = {9'h000, carrier, os_act, db_b, db_a,
                      out_b_q, out_a_q};

endmodule : pwm_deadband_chopper_stage

`default_nettype wire

// ### gate_drive_monitor.sv
`timescale 1ns/1ps
`default_nettype none

// ====================================================================
// gate driver model: tallies the clocks its drive pulse is high
// ====================================================================
module gate_drive_monitor (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // drive pulse from the stage
   input  wire logic        pulse,
   // delivered on-time, in clocks
   output logic      [15:0] high_cnt
);
   // a pulse transformer only passes high time, so that is what we count
   always_ff @(posedge clk) begin
      if (rst) begin
         high_cnt <= 16'h0000;
      end else if (pulse) begin
         high_cnt <= high_cnt + 16'h0001;
      end
   end
endmodule : gate_drive_monitor

`default_nettype wire

// ### pwm_stage_chk_sva.sv
`timescale 1ns/1ps
`default_nettype none

// ====================================================================
// port checker for the dead-band and chopper stage
// ====================================================================
module pwm_stage_chk (
   // clock and reset
   input  wire logic        CLK,
   input  wire logic        RST,
   // bus
   input  wire logic        HSEL,
   input  wire logic [31:0] HADDR,
   input  wire logic [1:0]  HTRANS,
   input  wire logic        HWRITE,
   input  wire logic [31:0] HWDATA,
   input  wire logic        HREADY,
   input  wire logic [31:0] HRDATA,
   input  wire logic        HREADYOUT,
   input  wire logic        HRESP,
   // pwm path
   input  wire logic        PWM_A_IN,
   input  wire logic        PWM_B_IN,
   input  wire logic        PWM_A_OUT,
   input  wire logic        PWM_B_OUT
);
   import pwm_stage_pkg::*;

   // ==================================================================
   // shadow of the control registers, rebuilt from bus traffic
   // ==================================================================
   wire  logic       take = HSEL && HREADY && (HTRANS == HTRANS_NONSEQ);
   wire  logic [7:0] idx  = HADDR[9:2];
   wire  logic       mapped = (idx == IDX_DB_CTRL) || (idx == IDX_RISE) ||
                      (idx == IDX_FALL) || (idx == IDX_CHOP) ||
                      (idx == IDX_STAT);
   logic             wr_q;     // write data phase pending
   logic [7:0]       widx_q;   // its word index
   logic [7:0]       db_q;     // dead-band control copy
   logic [10:0]      chop_q;   // chopper control copy
   logic [3:0]       quiet_q;  // clocks since last write
   // config must sit still a few clocks before the pipe reflects it
   wire  logic       settled = (quiet_q > 4'h3);

   // track writes as they land in the data phase
   always_ff @(posedge CLK) begin
      if (RST) begin
         wr_q    <= 1'b0;
         widx_q  <= 8'h00;
         db_q    <= 8'h00;
         chop_q  <= 11'h000;
         quiet_q <= 4'h0;
      end else begin
         wr_q    <= take && HWRITE;
         widx_q  <= idx;
         db_q    <= (wr_q && widx_q == IDX_DB_CTRL) ? HWDATA[7:0] : db_q;
         chop_q  <= (wr_q && widx_q == IDX_CHOP) ? HWDATA[10:0] : chop_q;
         quiet_q <= wr_q ? 4'h0 : quiet_q + {3'h0, quiet_q != 4'hF};
      end
   end

   // ==================================================================
   // assertions
   // ==================================================================
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);

   // read address phase to a given word
   sequence s_rd(logic [7:0] i);
      take && !HWRITE && (idx == i);
   endsequence
   // read address phase to a hole in the map
   sequence s_rd_hole;
      take && !HWRITE && !mapped;
   endsequence

   a_ready_high: assert property (HREADYOUT)
      else $error("slave inserted a wait state");
   a_resp_okay: assert property (HRESP == HRESP_OKAY)
      else $error("slave answered with an error");
   a_reset_quiet: assert property ($past(RST) |->
      !PWM_A_OUT && !PWM_B_OUT && HRDATA == 32'h0)
      else $error("outputs not quiet after reset");
   a_direct_a: assert property (
      settled && !db_q[1] && !chop_q[0] |-> PWM_A_OUT == $past(PWM_A_IN, 2))
      else $error("undelayed channel a does not follow its input");
   a_direct_b: assert property (
      settled && !db_q[0] && !chop_q[0] |-> PWM_B_OUT == $past(PWM_B_IN, 2))
      else $error("undelayed channel b does not follow its input");
   a_chop_gate: assert property (
      settled && chop_q[0] && db_q[1:0] == 2'b00 |->
      !PWM_A_OUT || $past(PWM_A_IN, 2))
      else $error("chopped output high while pwm low");
   a_rd_hole: assert property (s_rd_hole |=> HRDATA == 32'h0)
      else $error("unmapped read not zero");
   a_rd_deadband_control: assert property (
      s_rd(IDX_DB_CTRL) |=> HRDATA == {24'h0, db_q})
      else $error("dead-band control read back wrong");
   a_rd_chop: assert property (
      s_rd(IDX_CHOP) |=> HRDATA == {21'h0, chop_q})
      else $error("chopper control read back wrong");

endmodule : pwm_stage_chk

bind pwm_deadband_chopper_stage pwm_stage_chk i_chk (
   .CLK(CLK), .RST(RST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
   .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA),
   .HREADYOUT(HREADYOUT), .HRESP(HRESP), .PWM_A_IN(PWM_A_IN),
   .PWM_B_IN(PWM_B_IN), .PWM_A_OUT(PWM_A_OUT), .PWM_B_OUT(PWM_B_OUT));

`default_nettype wire

// ### tb_pwm_deadband_chopper_stage.sv
`timescale 1ns/1ps
`default_nettype none

// ====================================================================
// self-checking bench for the dead-band and chopper stage
// ====================================================================
module tb_pwm_deadband_chopper_stage;
   import pwm_stage_pkg::*;

   logic        clk = 1'b0;    // 250 MHz
   logic        rst = 1'b1;    // sync, active high
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic        a_in = 1'b0;
   logic        b_in = 1'b0;
   logic        a_out;
   logic        b_out;
   logic [15:0] high_cnt;      // on-time seen by the a-side driver
   int          num_errors = 0;
   int          checks = 0;
   int          seed = 32'h5963;
   logic [7:0]  regs [6] = '{IDX_DB_CTRL, IDX_RISE, IDX_FALL, IDX_CHOP,
                             8'h00, 8'h20};

   always #2 clk = ~clk;

   pwm_deadband_chopper_stage i_dut (
      .CLK(clk), .RST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
      .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout),
      .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp),
      .PWM_A_IN(a_in), .PWM_B_IN(b_in), .PWM_A_OUT(a_out),
      .PWM_B_OUT(b_out));

   gate_drive_monitor i_drv (
      .clk(clk), .rst(rst), .pulse(a_out), .high_cnt(high_cnt));

   // ==================================================================
   // reporting
   // ==================================================================
   task conclude;
      $display("checks=%0d num_errors=%0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : conclude

   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // ==================================================================
   // bus master: hold each phase until ready is sampled high
   // ==================================================================
   task wait_rdy;
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (hreadyout !== 1'b1 && n < 32);
      if (n >= 32) begin
         num_errors++;
         conclude();
      end
   endtask : wait_rdy

   task bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
            output logic [31:0] rd);
      hsel   <= 1'b1;
      htrans <= HTRANS_NONSEQ;
      haddr  <= {22'h0, idx, 2'h0};
      hwrite <= wr;
      wait_rdy();
      htrans <= 2'h0;
      hwdata <= wd;
      wait_rdy();
      rd = hrdata;
   endtask : bus

   // ==================================================================
   // expectations
   // ==================================================================
   function automatic logic [31:0] rd_exp(input logic [7:0] i,
                                          input logic [31:0] d);
      case (i)
         IDX_DB_CTRL: rd_exp = d & {16'h0, DB_CTRL_MSK};
         IDX_RISE, IDX_FALL: rd_exp = d & 32'h0000_03FF;
         IDX_CHOP: rd_exp = d & {16'h0, CHOP_MSK};
         default: rd_exp = 32'h0;
      endcase
   endfunction : rd_exp

   // zero delay counts: {a, b} as seen two clocks later
   function automatic logic [1:0] db_exp(input logic [7:0] c,
                                         input logic a, input logic b);
      logic rs;
      logic fs;
      rs = c[4] ? b : a;
      fs = c[5] ? b : a;
      db_exp = {c[1] ? rs ^ c[2] : a, c[0] ? fs ^ c[3] : b};
   endfunction : db_exp

   // time an edge; the undelayed partner must have moved at two clocks
   task meas(input logic up, output int n);
      n = 0;
      do begin
         @(posedge clk);
         #1;
         n++;
         if (n == 2) chk({31'h0, up ? b_out : a_out}, 32'h0);
      end while ((up ? a_out : b_out) !== 1'b1 && n < 2000);
      if (n >= 2000) begin
         num_errors++;
         conclude();
      end
   endtask : meas

   // ==================================================================
   // main sequence
   // ==================================================================
   initial begin
      logic [31:0] rd, d, o, e;
      logic [7:0]  c;
      logic [2:0]  ha, hb;
      logic [15:0] h;
      int          n, r, f, w;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      // reset values, masks and two holes in the map
      for (int i = 0; i < 6; i++) begin
         bus(1'b0, regs[i], 32'h0, rd);
         chk(rd, 32'h0);
         d = $random(seed);
         bus(1'b1, regs[i], d, rd);
         bus(1'b0, regs[i], 32'h0, rd);
         chk(rd, rd_exp(regs[i], d));
      end
      // every mode, polarity and source with zero delays, chopper off
      bus(1'b1, IDX_RISE, 32'h0, rd);
      bus(1'b1, IDX_FALL, 32'h0, rd);
      bus(1'b1, IDX_CHOP, 32'h0, rd);
      for (int k = 0; k < 64; k++) begin
         c = {2'b00, 6'(k)};
         bus(1'b1, IDX_DB_CTRL, {24'h0, c}, rd);
         repeat (4) @(posedge clk);
         for (int j = 0; j < 12; j++) begin
            @(posedge clk);
            d = $random(seed);
            a_in <= d[0];
            b_in <= d[1];
            ha = {ha[1:0], d[0]};
            hb = {hb[1:0], d[1]};
            #1;
            o = {30'h0, a_out, b_out};
            e = {30'h0, db_exp(c, ha[2], hb[2])};
            if (j > 1) chk(o, e);
         end
      end
      // complementary pair, longest fall first, then tick divided by two
      b_in <= 1'b0;
      for (int k = 0; k < 2; k++) begin
         bus(1'b1, IDX_DB_CTRL, k ? 32'h0000_004B : 32'h0000_000B, rd);
         r = k ? ($random(seed) & 63) + 1 : 1;
         f = k ? ($random(seed) & 63) + 1 : 1023;
         bus(1'b1, IDX_RISE, 32'(r), rd);
         bus(1'b1, IDX_FALL, 32'(f), rd);
         a_in <= 1'b0;
         repeat (f + 8) @(posedge clk);
         a_in <= 1'b1;
         meas(1'b1, n);
         chk(32'((n - 3) >> k), 32'(r - 1));
         @(posedge clk) a_in <= 1'b0;
         meas(1'b0, n);
         chk(32'((n - 3) >> k), 32'(f - 1));
      end
      // chopper: first pulse then carrier duty, every duty code
      bus(1'b1, IDX_DB_CTRL, 32'h0, rd);
      for (int dd = 0; dd < 8; dd++) begin
         d = $random(seed);
         w = 8 * (int'(d[3:0]) + 1);
         f = int'(d[6:4]) + 1;
         bus(1'b1, IDX_CHOP, {21'h0, 3'(dd), d[6:4], d[3:0], 1'b1}, rd);
         a_in <= 1'b0;
         repeat (20) @(posedge clk);
         a_in <= 1'b1;
         meas(1'b1, n);
         chk(32'(n), 32'h2);
         h = high_cnt;
         repeat (w) @(posedge clk);
         #1;
         chk(32'(high_cnt - h), 32'(w));
         h = high_cnt;
         repeat (32 * f) @(posedge clk);
         #1;
         e = 32'(4 * ((dd > 6 ? 6 : dd) + 1) * f);
         chk(32'(high_cnt - h), e);
      end
      conclude();
   end

endmodule : tb_pwm_deadband_chopper_stage

`default_nettype wire
